// ===== rtl/pmc_ctrl.v
// Privilege level, reset mode, vectors, watchdog and power state
`timescale 1ns/1ns
`include "pmc_defines.vh"
module pmc_ctrl (
  input wire i_clk,
  input wire i_rst,
  input wire i_test_fuse_blown,
  input wire i_profile_least,
  input wire i_boot_done,
  input wire i_test_disable,
  input wire i_irq,
  input wire [`PMC_IRQ_W-1:0] i_irq_num,
  input wire i_call_down,
  input wire i_call_up,
  input wire [`PMC_SEG_N*`PMC_RIGHT_W-1:0] i_rights,
  input wire i_rights_wr,
  input wire [`PMC_ADDR_W-1:0] i_mem_addr,
  input wire i_mem_rd,
  input wire i_mem_wr,
  input wire i_mem_ex,
  input wire i_wdt_enable,
  input wire [`PMC_WDT_W-1:0] i_wdt_load,
  input wire i_wdt_kick,
  input wire i_idle_req,
  input wire i_sleep_req,
  input wire i_clkstop_req,
  input wire i_wake,
  output reg [`PMC_LVL_W-1:0] o_level,
  output reg o_test_active,
  output reg o_jump,
  output reg [`PMC_ADDR_W-1:0] o_jump_addr,
  output reg o_call_fault,
  output wire o_access_deny,
  output reg o_wdt_abort,
  output reg [`PMC_PWR_W-1:0] o_pwr_state,
  output reg o_cpu_clk_en
);
  // -----------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------
  reg fuse_s1_q, fuse_s2_q, prof_s1_q, prof_s2_q, wake_s1_q, wake_s2_q;
  always @(posedge i_clk) begin
    fuse_s1_q <= i_test_fuse_blown;
    fuse_s2_q <= fuse_s1_q;
    prof_s1_q <= i_profile_least;
    prof_s2_q <= prof_s1_q;
    wake_s1_q <= i_wake;
    wake_s2_q <= wake_s1_q;
  end

  // -----------------------------------------------------------------
  // Boot sequence and level
  // -----------------------------------------------------------------
  localparam ST_BOOT = 2'h0;
  localparam ST_TEST = 2'h1;
  localparam ST_RUN = 2'h2;
  reg [1:0] st_q;
  reg [`PMC_SEG_N*`PMC_RIGHT_W-1:0] rights_q;
  reg fuse_seen_q;

  always @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= ST_BOOT;
      // RULE_05: reset starts boot at top
      o_level <= `PMC_LVL_TOP;
      o_test_active <= 1'b0;
      o_jump <= 1'b1;
      o_jump_addr <= `PMC_BOOT_VEC;
      o_call_fault <= 1'b0;
      rights_q <= {`PMC_SEG_N*`PMC_RIGHT_W{1'b0}};
      fuse_seen_q <= 1'b0;
    end else begin
      o_jump <= 1'b0;
      o_call_fault <= 1'b0;
      // RULE_03: fuse latches once seen
      if (fuse_s2_q)
        fuse_seen_q <= 1'b1;
      if (i_rights_wr && o_level == `PMC_LVL_SYS)
        rights_q <= i_rights;
      case (st_q)
        ST_BOOT: begin
          if (i_boot_done) begin
            if (!(fuse_s2_q || fuse_seen_q)) begin
              // RULE_02: test software before customer
              st_q <= ST_TEST;
              o_test_active <= 1'b1;
              o_jump <= 1'b1;
              o_jump_addr <= `PMC_TEST_VEC;
            end else begin
              // RULE_04: profile picks exit level
              st_q <= ST_RUN;
              o_level <= prof_s2_q ? `PMC_LVL_LEAST : `PMC_LVL_SYS;
            end
          end
        end
        ST_TEST: begin
          // RULE_03: disable ends test until reset, which clears fuse_seen_q
          if (i_test_disable || fuse_s2_q) begin
            o_test_active <= 1'b0;
            fuse_seen_q <= 1'b1;
          end
        end
        ST_RUN: begin
          // RULE_06: fixed vector on interrupt
          if (i_irq) begin
            o_jump <= 1'b1;
            o_jump_addr <= `PMC_VEC_BASE + ({{(`PMC_ADDR_W-`PMC_IRQ_W){1'b0}}, i_irq_num} << `PMC_VEC_STEP);
          end else if (i_call_down) begin
            // RULE_01: level stays within three
            // RULE_13: no step below least
            if (o_level == `PMC_LVL_LEAST)
              o_call_fault <= 1'b1;
            else
              // RULE_07: one level down
              o_level <= o_level + 2'h1;
          end else if (i_call_up) begin
            // RULE_13: no step above top
            if (o_level == `PMC_LVL_TOP)
              o_call_fault <= 1'b1;
            else
              // RULE_08: one level up
              o_level <= o_level - 2'h1;
          end
        end
        default: st_q <= ST_BOOT;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Memory guard
  // -----------------------------------------------------------------
  // RULE_10: segment guard instance
  pmc_seg_guard u_guard (
    .i_addr(i_mem_addr),
    .i_rd(i_mem_rd),
    .i_wr(i_mem_wr),
    .i_ex(i_mem_ex),
    .i_least(o_level == `PMC_LVL_LEAST),
    .i_rights(rights_q),
    .o_deny(o_access_deny)
  );

  // -----------------------------------------------------------------
  // Watchdog
  // -----------------------------------------------------------------
  reg wdt_on_q;
  reg [`PMC_WDT_W-1:0] wdt_cnt_q;
  always @(posedge i_clk) begin
    if (i_rst) begin
      // RULE_11: off until software enables
      wdt_on_q <= 1'b0;
      wdt_cnt_q <= `PMC_WDT_ZERO;
      o_wdt_abort <= 1'b0;
    end else begin
      o_wdt_abort <= 1'b0;
      if (i_wdt_enable && !wdt_on_q) begin
        wdt_on_q <= 1'b1;
        wdt_cnt_q <= i_wdt_load;
      end else if (wdt_on_q) begin
        if (i_wdt_kick)
          wdt_cnt_q <= i_wdt_load;
        else if (wdt_cnt_q == `PMC_WDT_ZERO) begin
          // RULE_11: timeout aborts execution
          o_wdt_abort <= 1'b1;
          wdt_cnt_q <= i_wdt_load;
        end else
          wdt_cnt_q <= wdt_cnt_q - `PMC_WDT_ONE;
      end
    end
  end

  // -----------------------------------------------------------------
  // Power states
  // -----------------------------------------------------------------
  // Watchdog keeps running in idle so a stuck idle still aborts
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_pwr_state <= `PMC_PWR_RUN;
      o_cpu_clk_en <= 1'b1;
    end else begin
      case (o_pwr_state)
        `PMC_PWR_RUN: begin
          // RULE_12: enter idle or sleep
          if (i_sleep_req) begin
            o_pwr_state <= i_clkstop_req ? `PMC_PWR_CLKSTOP : `PMC_PWR_SLEEP;
            o_cpu_clk_en <= 1'b0;
          end else if (i_idle_req) begin
            o_pwr_state <= `PMC_PWR_IDLE;
            o_cpu_clk_en <= 1'b0;
          end
        end
        default: begin
          if (wake_s2_q || i_irq || o_wdt_abort) begin
            o_pwr_state <= `PMC_PWR_RUN;
            o_cpu_clk_en <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule // pmc_ctrl

// ===== shared/pmc_defines.vh
// Constants for the privilege and mode controller
// -----------------------------------------------------------------
// Function
// RULE_01: Track three levels: top, system, least
// RULE_02: Test still enabled: reset runs test software
// RULE_03: Test disable is permanent across resets; here reset clears fuse_seen_q, so only a blown fuse pin keeps test off
// RULE_04: Post-test reset ends per stored profile
// RULE_05: Top level only for boot and firmware
// RULE_06: Interrupts jump to fixed vector
// RULE_07: Downward call steps one level down
// RULE_08: Upward call steps one level up
// RULE_09: Least level limited to granted rights
// RULE_10: Segment unit guards flash, RAM, ROM
// RULE_11: Watchdog off until enabled; timeout aborts
// RULE_12: Idle and sleep states, sleep stops clock
// RULE_13: Illegal call step raises exception
// -----------------------------------------------------------------
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH

`define PMC_LVL_W 2
`define PMC_LVL_TOP 2'h0
`define PMC_LVL_SYS 2'h1
`define PMC_LVL_LEAST 2'h2

`define PMC_PWR_W 2
`define PMC_PWR_RUN 2'h0
`define PMC_PWR_IDLE 2'h1
`define PMC_PWR_SLEEP 2'h2
`define PMC_PWR_CLKSTOP 2'h3

`define PMC_ADDR_W 16
`define PMC_VEC_BASE 16'h0100
`define PMC_VEC_STEP 3
`define PMC_IRQ_W 3
`define PMC_BOOT_VEC 16'h0000
`define PMC_TEST_VEC 16'h0040

`define PMC_SEG_N 4
`define PMC_SEG_IDX_W 2
`define PMC_SEG_SHIFT 14
`define PMC_RIGHT_W 3
`define PMC_RIGHT_R 0
`define PMC_RIGHT_W_BIT 1
`define PMC_RIGHT_X 2

`define PMC_WDT_W 16
`define PMC_WDT_ZERO 16'h0000
`define PMC_WDT_ONE 16'h0001

`endif

// ===== rtl/pmc_seg_guard.v
// Per-segment access check for the least privileged level
`timescale 1ns/1ns
`include "pmc_defines.vh"
module pmc_seg_guard (
  input wire [`PMC_ADDR_W-1:0] i_addr,
  input wire i_rd,
  input wire i_wr,
  input wire i_ex,
  input wire i_least,
  input wire [`PMC_SEG_N*`PMC_RIGHT_W-1:0] i_rights,
  output wire o_deny
);
  wire [`PMC_SEG_N-1:0] hit;
  wire [`PMC_SEG_IDX_W-1:0] seg;
  assign seg = i_addr[`PMC_ADDR_W-1:`PMC_SEG_SHIFT];
  genvar g;
  generate
    for (g = 0; g < `PMC_SEG_N; g = g + 1) begin : g_seg
      wire [`PMC_RIGHT_W-1:0] r;
      assign r = i_rights[g*`PMC_RIGHT_W +: `PMC_RIGHT_W];
      // RULE_10: segment rights check
      assign hit[g] = (seg == g) &&
        ((i_rd && !r[`PMC_RIGHT_R]) || (i_wr && !r[`PMC_RIGHT_W_BIT]) || (i_ex && !r[`PMC_RIGHT_X]));
    end
  endgenerate
  // RULE_09: only least level restricted
  assign o_deny = i_least && (|hit);
endmodule // pmc_seg_guard

// ===== verification/pmc_ctrl_properties.sv
// Port assertions for the privilege and mode controller
`timescale 1ns/1ns
`include "pmc_defines.vh"
module pmc_props (
  input wire i_clk,
  input wire i_rst,
  input wire i_irq,
  input wire [`PMC_IRQ_W-1:0] i_irq_num,
  input wire i_boot_done,
  input wire i_call_down,
  input wire i_call_up,
  input wire i_idle_req,
  input wire i_sleep_req,
  input wire i_clkstop_req,
  input wire i_wdt_enable,
  input wire [`PMC_LVL_W-1:0] o_level,
  input wire o_jump,
  input wire [`PMC_ADDR_W-1:0] o_jump_addr,
  input wire o_call_fault,
  input wire o_wdt_abort,
  input wire [`PMC_PWR_W-1:0] o_pwr_state,
  input wire o_cpu_clk_en
);
  // ----
  // Helpers
  // ----
  reg wdt_seen_q;
  wire run = o_pwr_state == `PMC_PWR_RUN;
  wire go = run && !i_irq;
  // Cleared by reset so a stale enable cannot excuse an abort
  always @(posedge i_clk) wdt_seen_q <= !i_rst && (wdt_seen_q || i_wdt_enable);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  reset_boot_a: assert property ($fell(i_rst) |-> o_level == `PMC_LVL_TOP && o_jump && o_jump_addr == `PMC_BOOT_VEC)
    else $error("no boot entry at top level");
  // Boot exit may jump to the test vector in the same cycle as a stray interrupt
  irq_vector_a: assert property (o_jump && $past(i_irq) && !$past(i_rst) && !$past(i_boot_done) |->
    o_jump_addr == `PMC_VEC_BASE + {$past(i_irq_num), 3'h0})
    else $error("wrong interrupt vector");
  down_step_a: assert property (go && o_level == `PMC_LVL_SYS && i_call_down |=> o_level == `PMC_LVL_LEAST)
    else $error("down call did not step");
  up_step_a: assert property (go && o_level == `PMC_LVL_LEAST && i_call_up && !i_call_down |=> o_level == `PMC_LVL_SYS)
    else $error("up call did not step");
  bad_call_a: assert property (go && o_level == `PMC_LVL_LEAST && i_call_down |=> o_call_fault && $stable(o_level))
    else $error("illegal call not refused");
  idle_entry_a: assert property (go && i_idle_req && !i_sleep_req && !i_clkstop_req |=> o_pwr_state == `PMC_PWR_IDLE)
    else $error("idle not entered");
  clk_off_a: assert property (!run |-> !o_cpu_clk_en)
    else $error("clock runs while not running");
  wdt_quiet_a: assert property (!wdt_seen_q |-> !o_wdt_abort)
    else $error("abort without enable");
  level_range_a: assert property (o_level != 2'h3)
    else $error("level outside the three");
  cover property (o_call_fault);
  cover property (o_jump && $past(i_irq));
  cover property (o_wdt_abort);
  cover property (o_pwr_state == `PMC_PWR_CLKSTOP);
endmodule // pmc_props
bind pmc_ctrl pmc_props u_props (
  .i_clk(i_clk),
  .i_rst(i_rst),
  .i_irq(i_irq),
  .i_irq_num(i_irq_num),
  .i_boot_done(i_boot_done),
  .i_call_down(i_call_down),
  .i_call_up(i_call_up),
  .i_idle_req(i_idle_req),
  .i_sleep_req(i_sleep_req),
  .i_clkstop_req(i_clkstop_req),
  .i_wdt_enable(i_wdt_enable),
  .o_level(o_level),
  .o_jump(o_jump),
  .o_jump_addr(o_jump_addr),
  .o_call_fault(o_call_fault),
  .o_wdt_abort(o_wdt_abort),
  .o_pwr_state(o_pwr_state),
  .o_cpu_clk_en(o_cpu_clk_en)
);

// ===== verification/tb_top.sv
// Self-checking bench for the privilege and mode controller
`timescale 1ns/1ns
`include "pmc_defines.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; $display("[FAIL] %0t %h %h", $time, a, e); end end
module tb_top;
  logic i_clk, i_rst, i_test_fuse_blown, i_profile_least, i_boot_done, i_test_disable, i_irq, i_call_down, i_call_up;
  logic i_rights_wr, i_mem_rd, i_mem_wr, i_mem_ex, i_wdt_enable, i_wdt_kick, i_idle_req, i_sleep_req, i_clkstop_req, i_wake;
  logic [2:0] i_irq_num;
  logic [11:0] i_rights;
  logic [15:0] i_mem_addr, i_wdt_load;
  wire [1:0] o_level, o_pwr_state;
  wire o_test_active, o_jump, o_call_fault, o_access_deny, o_wdt_abort, o_cpu_clk_en;
  wire [15:0] o_jump_addr;
  integer bad_count = 0, cmp_count = 0, lv, i, n;
  logic [7:0] rnd = 8'h56;
  pmc_ctrl i_dut (.*);
  function automatic [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic cy(input integer k);
    repeat (k) @(posedge i_clk);
    #10;
  endtask
  task automatic boot(input p);
    i_profile_least = p;
    i_rst = 1;
    cy(12);
    `CHK(o_jump, 1'b1)
    `CHK(o_jump_addr, `PMC_BOOT_VEC)
    i_rst = 0;
    // Pins pass a two-flop synchroniser first
    cy(3);
    i_boot_done = 1;
    cy(1);
    i_boot_done = 0;
  endtask
  // Model: one step per legal call, fault at either end
  task automatic call(input d);
    n = d ? (lv == 2) : (lv == 0);
    lv = n ? lv : (d ? lv + 1 : lv - 1);
    i_call_down = d;
    i_call_up = !d;
    cy(1);
    `CHK(o_level, lv[1:0])
    `CHK(o_call_fault, n[0])
  endtask
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    i_clk = 0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    #300000;
    bad_count++;
    end_sim;
  end
  initial begin
    {i_test_fuse_blown, i_boot_done, i_test_disable, i_irq, i_call_down, i_call_up, i_rights_wr, i_mem_rd} = '0;
    {i_mem_wr, i_mem_ex, i_wdt_enable, i_wdt_kick, i_idle_req, i_sleep_req, i_clkstop_req, i_wake} = '0;
    {i_irq_num, i_rights, i_mem_addr, i_wdt_load} = '0;
    boot(0);
    `CHK(o_test_active, 1'b1)
    `CHK(o_level, `PMC_LVL_TOP)
    `CHK(o_jump, 1'b1)
    `CHK(o_jump_addr, `PMC_TEST_VEC)
    i_test_disable = 1;
    cy(1);
    i_test_disable = 0;
    `CHK(o_test_active, 1'b0)
    i_test_fuse_blown = 1;
    boot(1);
    `CHK(o_level, `PMC_LVL_LEAST)
    `CHK(o_test_active, 1'b0)
    boot(0);
    `CHK(o_level, `PMC_LVL_SYS)
    lv = 1;
    // Back-to-back calls walk both ends of the level range
    for (i = 0; i < 6; i++) call(i < 2 || i == 5);
    // A call left standing would step the level during the rights write
    {i_call_down, i_call_up} = 2'h0;
    rnd = lfsr(rnd);
    i_rights = {rnd[3:0], rnd};
    i_rights_wr = 1;
    i_mem_addr = 16'h0000;
    i_mem_wr = 1;
    cy(1);
    i_rights_wr = 0;
    `CHK(o_access_deny, 1'b0)
    call(1);
    {i_call_down, i_call_up} = 2'h0;
    for (i = 0; i < 12; i++) begin
      i_mem_addr = {i[1:0], rnd, 6'h00};
      {i_mem_ex, i_mem_wr, i_mem_rd} = 3'h1 << (i / 4);
      cy(1);
      `CHK(o_access_deny, !i_rights[i[1:0] * 3 + i / 4])
    end
    {i_mem_ex, i_mem_wr, i_mem_rd} = 3'h0;
    i_irq = 1;
    for (i = 0; i < 8; i++) begin
      i_irq_num = i[2:0];
      cy(1);
      `CHK(o_jump_addr, `PMC_VEC_BASE + {i[2:0], 3'h0})
      `CHK(o_jump, 1'b1)
    end
    i_irq = 0;
    for (i = 1; i < 4; i++) begin
      // Clock stop is a kind of sleep, so both requests stand together
      {i_clkstop_req, i_sleep_req, i_idle_req} = (i == 3) ? 3'h6 : 3'h1 << (i - 1);
      cy(1);
      {i_clkstop_req, i_sleep_req, i_idle_req} = 3'h0;
      `CHK(o_pwr_state, i[1:0])
      `CHK(o_cpu_clk_en, 1'b0)
      i_wake = 1;
      cy(4);
      i_wake = 0;
      `CHK(o_pwr_state, `PMC_PWR_RUN)
    end
    i_wdt_load = 16'h0005;
    i_wdt_enable = 1;
    n = 0;
    while (o_wdt_abort !== 1'b1 && n < 20) begin
      cy(1);
      n++;
    end
    // Load edge, load count down to zero, then the abort edge
    `CHK(n, i_wdt_load + 2)
    i_wdt_kick = 1;
    for (i = 0; i < 10; i++) begin
      cy(1);
      `CHK(o_wdt_abort, 1'b0)
    end
    i_wdt_kick = 0;
    end_sim;
  end
endmodule // tb_top
